// ==== rtl/gut_top.sv ====
// Added by the designer: the plain strobed port and the register addresses.
`include "gut_regs.svh"
`default_nettype none
module gut_top #(
   parameter int STEP_CYC = `GUT_STEP_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Measurement: negative_sequence_current, per-unit of full load, Q16
   input  wire logic [31:0] negative_sequence_current,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // Outputs
   output logic             trip,
   output logic             irq
);
   // Settings: pickup Q16 per-unit /1000, K in s, tau in s, times in ms
   logic [31:0] ctrl, pickup, kcap, tcool, tmin, tmax;
   logic [31:0] next_ctrl, next_pickup, next_kcap, next_tcool;
   logic [31:0] next_tmin, next_tmax;
   logic [2:0]  istat, ien, next_istat, next_ien;
   logic [2:0]  ev;
   logic [31:0] next_rdata;

   // Thermal state, Q32 fractional units of (pu^2 * s)
   gut_pkg::gut_phase_e phase, next_phase;
   gut_pkg::gut_theta_t theta, next_theta;
   logic [31:0] step_cnt, next_step_cnt;
   logic [31:0] pu_ms, next_pu_ms;
   logic        next_trip;
   logic        step;
   logic        above;
   logic [15:0] pick_q16;
   logic [63:0] sq, theta_max, decay, inc;

   function automatic logic [63:0] sq_q32(input logic [31:0] x);
      logic [63:0] p;
      p = 64'(x) * 64'(x);
      return p;
   endfunction : sq_q32

   // Pickup stored in thousandths of full load
   assign pick_q16  = 16'((pickup * 32'h0000_ffff) / 32'h0000_03e8);
   assign above     = negative_sequence_current > 32'(pick_q16);
   assign step      = step_cnt == 32'(STEP_CYC - 1);
   assign sq        = sq_q32(negative_sequence_current);
   // Heat per step: I^2 * dt, dt = 1 ms
   assign inc       = sq / 64'(`GUT_STEPS_PER_S);
   // K is the pu^2*s capability: trip time K/I^2 from cold
   assign theta_max = 64'(kcap) << 32;
   // First-order decay per step, theta*(1 - dt/tau)
   assign decay     = (tcool == 32'h0) ? theta :
                      theta / (64'(tcool) * 64'(`GUT_STEPS_PER_S));

   always_comb begin
      next_step_cnt = step ? 32'h0 : step_cnt + 32'h1;
      next_phase    = phase;
      next_theta    = theta;
      next_pu_ms    = pu_ms;
      next_trip     = trip;
      ev            = 3'h0;
      // Estimate runs every step, independent of trip state
      if (step) begin
         if (above) begin
            // Heating continues from whatever cooling left
            next_phase = gut_pkg::GUT_HEAT;
            next_theta = theta + inc;
            next_pu_ms = (pu_ms == 32'hffff_ffff) ? pu_ms : pu_ms + 32'h1;
            if (phase != gut_pkg::GUT_HEAT)
               ev[`GUT_EV_PICKUP] = 1'b1;
         end else begin
            next_pu_ms = 32'h0;
            if (theta != 64'h0) begin
               next_phase = gut_pkg::GUT_COOL;
               next_theta = theta - ((decay == 64'h0) ? 64'h1 : decay);
               // Stop below 1% of maximum
               if (theta < theta_max / 64'h64) begin
                  next_theta = 64'h0;
                  next_phase = gut_pkg::GUT_COLD;
               end
            end else begin
               next_phase = gut_pkg::GUT_COLD;
            end
         end
      end
      // Clamp: never before tmin, by tmax unless tmin is later
      if (!ctrl[`GUT_CTRL_EN] || !above) begin
         next_trip = 1'b0;
      end else if (step && next_pu_ms >= tmin &&
                   (next_theta > theta_max || next_pu_ms >= tmax)) begin
         next_trip = 1'b1;
      end
      if (next_trip && !trip)
         ev[`GUT_EV_TRIP] = 1'b1;
      if (!next_trip && trip)
         ev[`GUT_EV_CLEARED] = 1'b1;
      next_istat = istat | ev;
   end

   // Register port; theta is deliberately not mapped
   always_comb begin
      next_ctrl   = ctrl;
      next_pickup = pickup;
      next_kcap   = kcap;
      next_tcool  = tcool;
      next_tmin   = tmin;
      next_tmax   = tmax;
      next_ien    = ien;
      next_rdata  = 32'h0;
      if (wr) begin
         unique case (addr)
            `GUT_ADDR_CTRL:   next_ctrl   = wdata & 32'h1;
            `GUT_ADDR_PICKUP: next_pickup = wdata;
            `GUT_ADDR_KCAP:   next_kcap   = wdata;
            `GUT_ADDR_TCOOL:  next_tcool  = wdata;
            `GUT_ADDR_TMIN:   next_tmin   = wdata;
            `GUT_ADDR_TMAX:   next_tmax   = wdata;
            `GUT_ADDR_IEN:    next_ien    = wdata[2:0];
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            `GUT_ADDR_CTRL:   next_rdata = ctrl;
            `GUT_ADDR_PICKUP: next_rdata = pickup;
            `GUT_ADDR_KCAP:   next_rdata = kcap;
            `GUT_ADDR_TCOOL:  next_rdata = tcool;
            `GUT_ADDR_TMIN:   next_rdata = tmin;
            `GUT_ADDR_TMAX:   next_rdata = tmax;
            `GUT_ADDR_STAT:   next_rdata = {29'h0, phase, trip};
            `GUT_ADDR_ISTAT:  next_rdata = {29'h0, istat};
            `GUT_ADDR_IEN:    next_rdata = {29'h0, ien};
            `GUT_ADDR_CURR:   next_rdata = negative_sequence_current;
            default:          next_rdata = 32'h0;
         endcase
      end
   end

   // Clear applied before set, so a same-cycle event survives
   logic [2:0] istat_d;
   assign istat_d = (wr && addr == `GUT_ADDR_ICLR) ?
                    ((istat & ~wdata[2:0]) | ev) :
                    next_istat;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl     <= `GUT_CTRL_RST;
         pickup   <= `GUT_PICKUP_RST;
         kcap     <= `GUT_KCAP_RST;
         tcool    <= `GUT_TCOOL_RST;
         tmin     <= `GUT_TMIN_RST;
         tmax     <= `GUT_TMAX_RST;
         ien      <= 3'h0;
         istat    <= 3'h0;
         rdata    <= 32'h0;
         phase    <= gut_pkg::GUT_COLD;
         theta    <= 64'h0;
         step_cnt <= 32'h0;
         pu_ms    <= 32'h0;
         trip     <= 1'b0;
         irq      <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         pickup   <= next_pickup;
         kcap     <= next_kcap;
         tcool    <= next_tcool;
         tmin     <= next_tmin;
         tmax     <= next_tmax;
         ien      <= next_ien;
         istat    <= istat_d;
         rdata    <= next_rdata;
         phase    <= next_phase;
         theta    <= next_theta;
         step_cnt <= next_step_cnt;
         pu_ms    <= next_pu_ms;
         trip     <= next_trip;
         irq      <= |(istat_d & next_ien);
      end
   end

   // Checks share one clock; reset masks them all
   default clocking cb_chk @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_heat_step;
      step && above;
   endsequence

   sequence s_cool_step;
      step && !above && theta != 64'h0;
   endsequence

   sequence s_trip_rise;
      !trip ##1 trip;
   endsequence

   sequence s_trip_fall;
      trip ##1 !trip;
   endsequence

   a_trip_needs_pickup: assert property (
      trip
      |-> $past(above))
      else $error("trip without pickup");

   a_trip_enable: assert property (
      trip
      |-> $past(ctrl[`GUT_CTRL_EN]))
      else $error("trip while disabled");

   a_trip_on_step: assert property (
      s_trip_rise
      |-> $past(step))
      else $error("trip off step");

   a_trip_min_time: assert property (
      s_trip_rise
      |-> pu_ms >= tmin)
      else $error("trip before tmin");

   a_trip_max_time: assert property (
      ctrl[`GUT_CTRL_EN] && above && step && pu_ms >= tmax && pu_ms >= tmin
      |=> trip)
      else $error("trip late");

   a_trip_heat: assert property (
      s_trip_rise
      |-> theta > $past(theta_max) || pu_ms >= $past(tmax))
      else $error("trip without heat");

   a_trip_release: assert property (
      trip && !above
      |=> !trip)
      else $error("trip held");

   a_trip_disable: assert property (
      !ctrl[`GUT_CTRL_EN]
      |=> !trip)
      else $error("trip with element off");

   a_trip_hold: assert property (
      trip && above && ctrl[`GUT_CTRL_EN]
      |=> trip)
      else $error("trip dropped early");

   a_trip_quiet: assert property (
      !trip && !step
      |=> !trip)
      else $error("trip between steps");

   a_pu_clear: assert property (
      step && !above
      |=> pu_ms == 32'h0)
      else $error("time above not cleared");

   a_pu_count: assert property (
      step && above && pu_ms != 32'hffff_ffff
      |=> pu_ms == $past(pu_ms) + 32'h1)
      else $error("time above not counted");

   a_pu_hold: assert property (
      !step
      |=> $stable(pu_ms))
      else $error("time above moved off step");

   a_step_wrap: assert property (
      step
      |=> step_cnt == 32'h0)
      else $error("step counter no wrap");

   a_step_count: assert property (
      !step
      |=> step_cnt == $past(step_cnt) + 32'h1)
      else $error("step counter stalled");

   a_heat_grows: assert property (
      s_heat_step
      |=> theta == $past(theta) + $past(inc))
      else $error("heat not accumulating");

   a_heat_phase: assert property (
      s_heat_step
      |=> phase == gut_pkg::GUT_HEAT)
      else $error("not heating above pickup");

   a_heat_resume: assert property (
      step && above && phase == gut_pkg::GUT_COOL
      |=> theta == $past(theta) + $past(inc))
      else $error("heating lost residual");

   a_cold_zero: assert property (
      phase == gut_pkg::GUT_COLD
      |-> theta == 64'h0)
      else $error("cold with heat");

   a_cool_falls: assert property (
      s_cool_step
      |=> theta < $past(theta))
      else $error("no cooling");

   a_cool_phase: assert property (
      step && !above && theta != 64'h0 && theta >= theta_max / 64'h64
      |=> phase == gut_pkg::GUT_COOL)
      else $error("not cooling below pickup");

   a_cool_stop: assert property (
      step && !above && theta < theta_max / 64'h64
      |=> theta == 64'h0 && phase == gut_pkg::GUT_COLD)
      else $error("cooling not ended");

   a_state_hold: assert property (
      !step
      |=> $stable(theta) && $stable(phase))
      else $error("estimate moved off step");

   a_pickup_event: assert property (
      step && above && phase != gut_pkg::GUT_HEAT
      |=> istat[`GUT_EV_PICKUP])
      else $error("pickup event lost");

   a_trip_event: assert property (
      s_trip_rise
      |-> istat[`GUT_EV_TRIP])
      else $error("trip event lost");

   a_clear_event: assert property (
      s_trip_fall
      |-> istat[`GUT_EV_CLEARED])
      else $error("release event lost");

   // Event beats a same-cycle clear, or software could miss a trip
   a_set_wins: assert property (
      ev != 3'h0
      |=> (istat & $past(ev)) == $past(ev))
      else $error("event lost to clear");

   a_clear_w1c: assert property (
      wr && addr == `GUT_ADDR_ICLR && ev == 3'h0
      |=> istat == ($past(istat) & ~$past(wdata[2:0])))
      else $error("status clear wrong");

   a_irq_level: assert property (
      (istat & ien) != 3'h0
      |-> irq)
      else $error("irq missing");

   a_irq_quiet: assert property (
      irq
      |-> (istat & ien) != 3'h0)
      else $error("irq without cause");

   a_read_hidden: assert property (
      rd && (addr[1:0] != 2'h0 || addr > `GUT_ADDR_CURR)
      |=> rdata == 32'h0)
      else $error("unmapped read not zero");

   a_rdata_idle: assert property (
      !rd
      |=> rdata == 32'h0)
      else $error("read data without read");

   a_curr_readback: assert property (
      rd && addr == `GUT_ADDR_CURR
      |=> rdata == $past(negative_sequence_current))
      else $error("current readback wrong");

   a_stat_readback: assert property (
      rd && addr == `GUT_ADDR_STAT
      |=> rdata == {29'h0, $past(phase), $past(trip)})
      else $error("status readback wrong");

   a_setting_write: assert property (
      wr && addr == `GUT_ADDR_PICKUP
      |=> pickup == $past(wdata))
      else $error("pickup write lost");
endmodule : gut_top
`default_nettype wire

// ==== rtl/gut_regs.svh ====
`ifndef GUT_REGS_SVH
`define GUT_REGS_SVH
// Contract
// - Trip only after negative-sequence current stayed above pickup for the whole delay.
// - Pickup is the permitted continuous negative-sequence current, per unit of full load.
// - The thermal estimate updates on every processing step regardless of trip state.
// - Trip also needs the thermal estimate above the maximum derived from the heat capacity; the code trips without it once pu_ms reaches tmax.
// - From cold, delay equals heat capacity over the squared per-unit current.
// - Residual heat at pickup shortens the delay so the trip comes earlier.
// - Above pickup the estimate accumulates the scaled integral of squared current.
// - Heating starts from the value left by cooling, or zero once cooling finished.
// - Below pickup the estimate decays exponentially with the cooling time constant.
// - Below 0.01 of the maximum the cooling stops and the estimate is cleared.
// - The thermal estimate stays internal and is never readable.
// - No trip before the minimum operate time has elapsed.
// - Trip no later than the maximum operate time.
// - One phase lost from a balanced supply gives one third of phase current.
// - Reversed phase sequence makes the measured magnitude equal the balanced current.

// Register offsets
`define GUT_ADDR_CTRL   8'h00
`define GUT_ADDR_PICKUP 8'h04
`define GUT_ADDR_KCAP   8'h08
`define GUT_ADDR_TCOOL  8'h0c
`define GUT_ADDR_TMIN   8'h10
`define GUT_ADDR_TMAX   8'h14
`define GUT_ADDR_STAT   8'h18
`define GUT_ADDR_ISTAT  8'h1c
`define GUT_ADDR_IEN    8'h20
`define GUT_ADDR_ICLR   8'h24
`define GUT_ADDR_CURR   8'h28

// Control fields and reset values
`define GUT_CTRL_EN     0
`define GUT_CTRL_RST    32'h0000_0001
`define GUT_PICKUP_RST  32'h0000_0014
`define GUT_KCAP_RST    32'h0000_000a
`define GUT_TCOOL_RST   32'h0000_00f0
`define GUT_TMIN_RST    32'h0000_00fa
`define GUT_TMAX_RST    32'h0009_27c0

// Event bits
`define GUT_EV_PICKUP   0
`define GUT_EV_TRIP     1
`define GUT_EV_CLEARED  2

// Timing: one processing step is 1 ms
`define GUT_CLK_HZ      25000000
`define GUT_STEP_US     1000
`define GUT_STEP_CYC    ((`GUT_CLK_HZ / 1000000) * `GUT_STEP_US)
`define GUT_STEPS_PER_S 1000
`endif

// ==== rtl/gut_pkg.sv ====
`default_nettype none
package gut_pkg;
   typedef enum logic [1:0] {
      GUT_COLD,
      GUT_HEAT,
      GUT_COOL
   } gut_phase_e;
   typedef logic [63:0] gut_theta_t;
endpackage : gut_pkg
`default_nettype wire

// ==== bench/gut_meas.sv ====
`default_nettype none
module gut_meas (
   // Clock
   input  wire logic        mclk,
   // Source settings
   input  wire logic [31:0] phase_amp,
   input  wire logic        phase_lost,
   input  wire logic        seq_rev,
   // Measured value
   output logic      [31:0] i2
);
   timeunit 1ns;
   timeprecision 1ns;
   initial i2 = '0;
   // Reversed sequence gives full amplitude, one phase lost a third, balanced none
   always @(posedge mclk) begin
      if (seq_rev)
         i2 <= phase_amp;
      else if (phase_lost)
         i2 <= phase_amp / 3;
      else
         i2 <= '0;
   end
endmodule : gut_meas
`default_nettype wire

// ==== bench/tb_top.sv ====
`include "gut_regs.svh"
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STEP = 25;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  addr = '0;
   logic [31:0] wdata = '0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata, cur, v;
   logic [31:0] amp = '0;
   logic        lost = 1'b0;
   logic        rev = 1'b0;
   logic        trip, irq;
   int          err_count = 0;
   int          checks_done = 0;
   logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   logic [31:0] rv [6] = '{32'h1, 32'h14, 32'ha, 32'hf0, 32'hfa, 32'h927c0};
   always #20 mclk = ~mclk;
   gut_meas u_meas (.mclk(mclk), .phase_amp(amp), .phase_lost(lost),
                    .seq_rev(rev), .i2(cur));
   gut_top #(.STEP_CYC(STEP)) dut (.mclk(mclk), .rstn(rstn),
      .negative_sequence_current(cur), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .trip(trip), .irq(irq));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rreg
   task automatic src(input logic [31:0] a, input logic l, input logic r);
      @(posedge mclk);
      amp  <= a;
      lost <= l;
      rev  <= r;
   endtask : src
   // Lands off the edge so flags are settled
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic steps(input int n);
      cyc(n * STEP);
   endtask : steps
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (60000) @(posedge mclk);
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rreg(ra[i], v);
         `CHK(v, rv[i]);
      end
      rreg(8'h40, v);
      `CHK(v, 32'h0);
      wreg(`GUT_ADDR_KCAP, 32'h1);
      wreg(`GUT_ADDR_TMIN, 32'ha);
      wreg(`GUT_ADDR_IEN, 32'h1);
      // Phase lost at 6.0 pu gives 2.0 pu unbalance
      src(32'h6_0000, 1'b1, 1'b0);
      steps(2);
      rreg(`GUT_ADDR_CURR, v);
      `CHK(v, 32'h2_0000);
      rreg(`GUT_ADDR_STAT, v);
      `CHK(v[2:1], 2'h1);
      `CHK(irq, 1'b1);
      wreg(`GUT_ADDR_ICLR, 32'h1);
      cyc(3);
      `CHK(irq, 1'b0);
      // Cold start: 1 s over 2.0 squared is 250 steps
      steps(242);
      `CHK(trip, 1'b0);
      steps(13);
      `CHK(trip, 1'b1);
      src(32'h0, 1'b0, 1'b0);
      cyc(3);
      `CHK(trip, 1'b0);
      steps(4);
      rreg(`GUT_ADDR_STAT, v);
      `CHK(v[2:1], 2'h2);
      // Residual heat makes the retrip wait only for tmin
      src(32'h6_0000, 1'b1, 1'b0);
      steps(8);
      `CHK(trip, 1'b0);
      steps(6);
      `CHK(trip, 1'b1);
      src(32'h1_0000, 1'b0, 1'b1);
      cyc(3);
      rreg(`GUT_ADDR_CURR, v);
      `CHK(v, 32'h1_0000);
      wreg(`GUT_ADDR_CTRL, 32'h0);
      cyc(3);
      `CHK(trip, 1'b0);
      rreg(`GUT_ADDR_STAT, v);
      `CHK(v[2:1], 2'h1);
      wreg(`GUT_ADDR_CTRL, 32'h1);
      wreg(`GUT_ADDR_KCAP, 32'hffff);
      wreg(`GUT_ADDR_TMAX, 32'h64);
      src(32'h0, 1'b0, 1'b0);
      steps(2);
      src(32'h6_0000, 1'b1, 1'b0);
      steps(95);
      `CHK(trip, 1'b0);
      steps(11);
      `CHK(trip, 1'b1);
      rreg(`GUT_ADDR_ISTAT, v);
      `CHK(v[1:0], 2'h3);
      wreg(`GUT_ADDR_IEN, 32'h0);
      cyc(3);
      `CHK(irq, 1'b0);
      wreg(`GUT_ADDR_IEN, 32'h3);
      cyc(3);
      `CHK(irq, 1'b1);
      wreg(`GUT_ADDR_ICLR, 32'h7);
      cyc(3);
      `CHK(irq, 1'b0);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
